// ### nand_config_descriptor.v
// nand_config_descriptor.v: configuration descriptor loader of the flash controller
// assumes: cpu special-function bus gives one-cycle write/read strobes on the
// config port; inputs synchronous to ref_clk
//
// Operation
// - clocked and writable only when enabled
// - controller runs basic operations; software sequences
// - first write is byte zero, ascending
// - new descriptor replaces previous configuration
// - byte zero main pages, one card
// - page size field bits 7-3, 512-byte units
// - reserved page config bits read zero
// - bits 4-1 select protected devices
// - bit 0 enables removable card support
// - device sub config resets to 1eh
// - block size code gives 32..256 pages
// - pages per block converts page to block
// - bytes 4-5 first protected block, reset zero
// - bytes 6-7 last protected block
// - up to four devices, three plus card
// - page sizes 512 to 8192 bytes; the 5-bit unit field is not limited and decodes 0 to 15872 bytes
// - hardware protects application segment blocks
`timescale 1ns/1ps
`include "nand_config_map.vh"

module nand_config_descriptor
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // controller control register bit
  input  wire        controller_enable_bit,
  // config port on cpu bus
  input  wire        config_port_wr,
  input  wire [7:0]  config_port_wdata,
  input  wire        config_port_rd,
  output reg  [7:0]  config_port_rdata_ff,
  output wire [2:0]  byte_pointer,
  output reg         descriptor_done_ff,
  // decoded configuration
  output wire [7:0]  main_page_config,
  output wire [7:0]  card_page_config,
  output wire [7:0]  device_sub_config,
  output wire [7:0]  block_sub_config,
  output wire [4:0]  main_page_size_units,
  output wire [4:0]  card_page_size_units,
  output wire [13:0] main_page_bytes,
  output wire [13:0] card_page_bytes,
  output wire [1:0]  device_count_minus_one,
  output wire [3:0]  protected_device_select,
  output wire        card_support_enable,
  output wire [1:0]  pages_per_block_code,
  output wire [8:0]  pages_per_block,
  output wire [15:0] first_block,
  output wire [15:0] last_block,
  output wire [3:0]  device_allowed,
  output wire        card_device_is_three,
  // protection check request
  input  wire [1:0]  dev_num,
  input  wire [23:0] page_addr,
  output wire [15:0] block_num,
  output reg         block_protected_ff
);

  reg  [2:0]  ptr_ff;
  reg  [2:0]  nxt_ptr;
  reg  [2:0]  rd_ptr_ff;
  reg  [2:0]  nxt_rd_ptr;
  reg         nxt_done;
  wire [63:0] all_bytes;
  wire [7:0]  store_rdata;
  wire        wr_ok;
  wire        rd_ok;
  wire        prot_now;
  reg         rd_pend_ff;

  // writes only while the controller clock is enabled
  assign wr_ok = config_port_wr & controller_enable_bit;
  assign rd_ok = config_port_rd & controller_enable_bit;

  // write pointer
  always @*
  begin
    nxt_ptr  = ptr_ff;
    nxt_done = descriptor_done_ff;
    if (wr_ok)
    begin
      nxt_ptr = ptr_ff + 3'h1;
      if (ptr_ff == `IDX_LAST)
        nxt_done = 1'b1;
    end
  end

  // read pointer walks the bytes the same way, reset by any write taken while enabled
  always @*
  begin
    nxt_rd_ptr = rd_ptr_ff;
    if (wr_ok)
      nxt_rd_ptr = 3'h0;
    else if (rd_ok)
      nxt_rd_ptr = rd_ptr_ff + 3'h1;
  end

  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ptr_ff             <= 3'h0;
      rd_ptr_ff          <= 3'h0;
      descriptor_done_ff <= 1'b0;
      rd_pend_ff         <= 1'b0;
    end
    else
    begin
      ptr_ff             <= nxt_ptr;
      rd_ptr_ff          <= nxt_rd_ptr;
      descriptor_done_ff <= nxt_done;
      rd_pend_ff         <= rd_ok;
    end
  end

  assign byte_pointer = ptr_ff;

  descriptor_store u_store
  (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .wr_en      (wr_ok),
    .wr_idx     (ptr_ff),
    .wr_data    (config_port_wdata),
    .rd_idx     (rd_ptr_ff),
    .rd_data_ff (store_rdata),
    .all_bytes  (all_bytes)
  );

  // read data held after a read strobe
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      config_port_rdata_ff <= 8'h00;
    else if (rd_pend_ff)
      config_port_rdata_ff <= store_rdata;
  end

  assign main_page_config  = all_bytes[8*`IDX_MAIN_PAGE_CONFIG+7 -: 8];
  assign card_page_config  = all_bytes[8*`IDX_CARD_PAGE_CONFIG+7 -: 8];
  assign device_sub_config = all_bytes[8*`IDX_DEVICE_SUB_CONFIG+7 -: 8];
  assign block_sub_config  = all_bytes[8*`IDX_BLOCK_SUB_CONFIG+7 -: 8];

  // page size units: bits 3..0 at 7..4, bit 4 at 3
  assign main_page_size_units = {main_page_config[`PAGE_UNITS_HI_BIT],
    main_page_config[`PAGE_UNITS_LO_MSB:`PAGE_UNITS_LO_LSB]};
  assign card_page_size_units = {card_page_config[`PAGE_UNITS_HI_BIT],
    card_page_config[`PAGE_UNITS_LO_MSB:`PAGE_UNITS_LO_LSB]};
  assign main_page_bytes = {main_page_size_units, 9'h000};
  assign card_page_bytes = {card_page_size_units, 9'h000};

  assign device_count_minus_one  =
    device_sub_config[`DEV_COUNT_MSB:`DEV_COUNT_LSB];
  assign protected_device_select =
    device_sub_config[`PROT_SEL_MSB:`PROT_SEL_LSB];
  assign card_support_enable     = device_sub_config[`CARD_EN_BIT];
  assign pages_per_block_code    =
    block_sub_config[`BSIZE_MSB:`BSIZE_LSB];
  assign pages_per_block = 9'h020 << pages_per_block_code;

  assign first_block = {all_bytes[8*`IDX_FIRST_PROT_HIGH+7 -: 8],
                        all_bytes[8*`IDX_FIRST_PROT_LOW+7 -: 8]};
  assign last_block  = {all_bytes[8*`IDX_LAST_PROT_HIGH+7 -: 8],
                        all_bytes[8*`IDX_LAST_PROT_LOW+7 -: 8]};

  // devices allowed for selection; card always sits on device three
  genvar d;
  generate
    for (d = 0; d < 4; d = d + 1)
    begin : g_dev
      if (d == 3)
      begin : g_card
        assign device_allowed[d] = card_support_enable |
                                   (device_count_minus_one == 2'h3);
      end
      else
      begin : g_plain
        assign device_allowed[d] = card_support_enable ?
          (d < device_count_minus_one) :
          (d <= device_count_minus_one);
      end
    end
  endgenerate

  assign card_device_is_three = card_support_enable;

  block_protect_check u_prot
  (
    .pages_per_block_code    (pages_per_block_code),
    .protected_device_select (protected_device_select),
    .first_block             (first_block),
    .last_block              (last_block),
    .dev_num                 (dev_num),
    .page_addr               (page_addr),
    .block_num               (block_num),
    .block_protected         (prot_now)
  );

  // registered protection verdict for the write path
  always @(posedge ref_clk)
  begin
    if (!rst_b)
      block_protected_ff <= 1'b0;
    else
      block_protected_ff <= prot_now & device_allowed[dev_num];
  end

endmodule // nand_config_descriptor

// ### nand_config_map.vh
// nand_config_map.vh: descriptor byte indices, field positions, reset values
// assumes: included by the descriptor loader and its helpers
`ifndef NAND_CONFIG_MAP_VH
`define NAND_CONFIG_MAP_VH

// descriptor byte indices
`define IDX_MAIN_PAGE_CONFIG      3'h0
`define IDX_CARD_PAGE_CONFIG      3'h1
`define IDX_DEVICE_SUB_CONFIG     3'h2
`define IDX_BLOCK_SUB_CONFIG      3'h3
`define IDX_FIRST_PROT_HIGH       3'h4
`define IDX_FIRST_PROT_LOW        3'h5
`define IDX_LAST_PROT_HIGH        3'h6
`define IDX_LAST_PROT_LOW         3'h7
`define IDX_LAST                  3'h7

// reset values
`define RST_MAIN_PAGE_CONFIG      8'h00
`define RST_CARD_PAGE_CONFIG      8'h00
`define RST_DEVICE_SUB_CONFIG     8'h1e
`define RST_BLOCK_SUB_CONFIG      8'h00
`define RST_PROT_BYTE             8'h00

// writable masks (reserved bits read as zero)
`define MASK_PAGE_CONFIG          8'hf8
`define MASK_DEVICE_SUB_CONFIG    8'h7f
`define MASK_BLOCK_SUB_CONFIG     8'h03

// field positions
`define PAGE_UNITS_LO_MSB         7
`define PAGE_UNITS_LO_LSB         4
`define PAGE_UNITS_HI_BIT         3
`define DEV_COUNT_MSB             6
`define DEV_COUNT_LSB             5
`define PROT_SEL_MSB              4
`define PROT_SEL_LSB              1
`define CARD_EN_BIT               0
`define BSIZE_MSB                 1
`define BSIZE_LSB                 0

// page size unit in bytes, shift for 512
`define PAGE_UNIT_SHIFT           9
`define CARD_DEVICE_NUM           2'h3

`endif

// ### descriptor_store.v
// descriptor_store.v: eight-byte descriptor memory with registered read port
// assumes: single clock, synchronous active-low reset, one write per cycle
`timescale 1ns/1ps
`include "nand_config_map.vh"

module descriptor_store
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // write port
  input  wire        wr_en,
  input  wire [2:0]  wr_idx,
  input  wire [7:0]  wr_data,
  // read port
  input  wire [2:0]  rd_idx,
  output reg  [7:0]  rd_data_ff,
  // all bytes flattened, byte n at [8n+7:8n]
  output wire [63:0] all_bytes
);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_byte
      // one register per byte, so each has a single driving process
      reg  [7:0] byte_ff;
      wire [7:0] mask;
      wire [7:0] rst_val;
      assign mask    = (g < 2) ? `MASK_PAGE_CONFIG :
                       (g == 2) ? `MASK_DEVICE_SUB_CONFIG :
                       (g == 3) ? `MASK_BLOCK_SUB_CONFIG : 8'hff;
      assign rst_val = (g == 2) ? `RST_DEVICE_SUB_CONFIG : 8'h00;
      always @(posedge ref_clk)
      begin
        if (!rst_b)
          byte_ff <= rst_val;
        else if (wr_en && (wr_idx == g))
          byte_ff <= wr_data & mask;
      end
      assign all_bytes[8*g+7:8*g] = byte_ff;
    end
  endgenerate

  always @(posedge ref_clk)
  begin
    if (!rst_b)
      rd_data_ff <= 8'h00;
    else
      rd_data_ff <= all_bytes[{rd_idx, 3'h0} +: 8];
  end

endmodule // descriptor_store

// ### block_protect_check.v
// block_protect_check.v: page address to block number, range and device check
// assumes: inputs are static configuration plus a page address from the controller
`timescale 1ns/1ps
`include "nand_config_map.vh"

module block_protect_check
(
  // configuration
  input  wire [1:0]  pages_per_block_code,
  input  wire [3:0]  protected_device_select,
  input  wire [15:0] first_block,
  input  wire [15:0] last_block,
  // request
  input  wire [1:0]  dev_num,
  input  wire [23:0] page_addr,
  // result
  output wire [15:0] block_num,
  output wire        block_protected
);

  reg [23:0] shifted;

  // block = page >> (5 + code): 32, 64, 128 or 256 pages
  always @*
  begin
    case (pages_per_block_code)
      2'h0:    shifted = page_addr >> 5;
      2'h1:    shifted = page_addr >> 6;
      2'h2:    shifted = page_addr >> 7;
      default: shifted = page_addr >> 8;
    endcase
  end

  assign block_num       = shifted[15:0];
  assign block_protected = protected_device_select[dev_num] &
                           (block_num >= first_block) &
                           (block_num <= last_block);

endmodule // block_protect_check

// ### desc_props.sv
// desc_props.sv: port assertions for the descriptor loader
// assumes: bound to nand_config_descriptor, single clock ref_clk
`timescale 1ns/1ps
module desc_props
(
  // clock and reset
  input logic        ref_clk,
  input logic        rst_b,
  // config port
  input logic        controller_enable_bit,
  input logic        config_port_wr,
  input logic [7:0]  config_port_wdata,
  input logic [2:0]  byte_pointer,
  input logic        descriptor_done_ff,
  // decoded configuration
  input logic [7:0]  main_page_config,
  input logic [7:0]  device_sub_config,
  input logic [7:0]  block_sub_config,
  input logic [8:0]  pages_per_block,
  input logic [23:0] page_addr,
  input logic [15:0] block_num
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire        wr_ok = config_port_wr && controller_enable_bit;
  // four-bit shift amount so that code 3 gives 8 and does not wrap to 0
  wire [23:0] blk_full = page_addr >> (4'h5 + block_sub_config[1:0]);

  a_ptr_advance: assert property (
    wr_ok |=> byte_pointer == $past(byte_pointer) + 3'h1) else $error("pointer stuck");
  a_write_refused: assert property (
    config_port_wr && !controller_enable_bit |=> $stable(byte_pointer)
    && $stable(main_page_config)) else $error("write taken while disabled");
  a_first_byte: assert property (
    wr_ok && byte_pointer == 3'h0 |=> main_page_config == ($past(config_port_wdata) & 8'hf8))
    else $error("byte 0 not stored");
  a_sub_byte: assert property (
    wr_ok && byte_pointer == 3'h2 |=> device_sub_config == ($past(config_port_wdata) & 8'h7f))
    else $error("byte 2 not stored");
  a_reserved_zero: assert property (
    main_page_config[2:0] == 3'h0 && block_sub_config[7:2] == 6'h00) else $error("reserved set");
  a_block_size: assert property (
    pages_per_block == (9'h020 << block_sub_config[1:0])) else $error("pages per block");
  a_block_number: assert property (
    block_num == blk_full[15:0]) else $error("block number");
  a_done_after_wrap: assert property (
    wr_ok && byte_pointer == 3'h7 |=> descriptor_done_ff ##1 descriptor_done_ff)
    else $error("done not set");
  c_wrap: cover property (wr_ok && byte_pointer == 3'h7);
  c_refused: cover property (config_port_wr && !controller_enable_bit);
  c_big_block: cover property (block_sub_config[1:0] == 2'h3);
endmodule // desc_props

bind nand_config_descriptor desc_props u_props
(
  .ref_clk(ref_clk), .rst_b(rst_b), .controller_enable_bit(controller_enable_bit),
  .config_port_wr(config_port_wr), .config_port_wdata(config_port_wdata),
  .byte_pointer(byte_pointer), .descriptor_done_ff(descriptor_done_ff),
  .main_page_config(main_page_config), .device_sub_config(device_sub_config),
  .block_sub_config(block_sub_config), .pages_per_block(pages_per_block),
  .page_addr(page_addr), .block_num(block_num)
);

// ### cpu_cfg_master.sv
// cpu_cfg_master.sv: cpu side of the config port, byte writes and reads
// assumes: strobes are taken on the rising edge of ref_clk
`timescale 1ns/1ps
module cpu_cfg_master
(
  // clock
  input  logic       ref_clk,
  // config port
  output logic       config_port_wr,
  output logic [7:0] config_port_wdata,
  output logic       config_port_rd,
  input  logic [7:0] config_port_rdata_ff
);
  initial
  begin
    config_port_wr = 1'b0;
    config_port_wdata = 8'h00;
    config_port_rd = 1'b0;
  end
  // one byte per access, after gap plus one idle cycles
  task automatic put(input logic [7:0] d, input int gap);
  begin
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    config_port_wr = 1'b1;
    config_port_wdata = d;
    @(posedge ref_clk);
    #1;
    config_port_wr = 1'b0;
    config_port_wdata = ~d; // released bus carries no stale byte
  end
  endtask
  // whole descriptor, byte 0 first, alternating prompt and slow
  task automatic load(input logic [63:0] desc);
  begin
    for (int i = 0; i < 8; i++)
      put(desc[8*i +: 8], i % 2);
  end
  endtask
  // read answer stands one edge after the strobe edge, sampled two edges after
  task automatic get(output logic [7:0] d);
  begin
    @(posedge ref_clk);
    #1;
    config_port_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    config_port_rd = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    d = config_port_rdata_ff;
  end
  endtask
endmodule // cpu_cfg_master

// ### tb_top.sv
// tb_top.sv: self-checking bench for the descriptor loader
// assumes: cpu_cfg_master drives the config port, desc_props is bound
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, rst_b, en, wr, rd, cse, done, bp, cd3;
  logic [1:0]  dev, dcm, ppbc;
  logic [4:0]  mpsu, cpsu;
  logic [2:0]  ptr;
  logic [3:0]  pds, dal;
  logic [7:0]  wd, rdat, mpc, cpc, dsc, bsc, rb;
  logic [8:0]  ppb;
  logic [13:0] mpb, cpb;
  logic [15:0] fb, lb, bn;
  logic [23:0] pa;
  logic [63:0] desc;
  int          miscompares = 0;
  int          checked = 0;

  cpu_cfg_master CPU (.ref_clk(ref_clk), .config_port_wr(wr), .config_port_wdata(wd),
    .config_port_rd(rd), .config_port_rdata_ff(rdat));
  nand_config_descriptor DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .controller_enable_bit(en), .config_port_wr(wr), .config_port_wdata(wd),
    .config_port_rd(rd), .config_port_rdata_ff(rdat), .byte_pointer(ptr),
    .descriptor_done_ff(done), .main_page_config(mpc), .card_page_config(cpc),
    .device_sub_config(dsc), .block_sub_config(bsc), .main_page_size_units(mpsu),
    .card_page_size_units(cpsu), .main_page_bytes(mpb), .card_page_bytes(cpb),
    .device_count_minus_one(dcm), .protected_device_select(pds),
    .card_support_enable(cse), .pages_per_block_code(ppbc), .pages_per_block(ppb),
    .first_block(fb), .last_block(lb), .device_allowed(dal), .card_device_is_three(cd3),
    .dev_num(dev), .page_addr(pa), .block_num(bn), .block_protected_ff(bp));

  task automatic check(input string what, input logic [15:0] seen, exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task automatic stop_test;
  begin
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end

  initial
  begin
    rst_b = 1'b0;
    en = 1'b0;
    dev = 2'h0;
    pa = 24'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    check("sub1 reset", dsc, 16'h1e);
    check("first reset", fb, 16'h0);
    CPU.put(8'h55, 0);
    check("pointer off", ptr, 16'h0);
    check("page off", mpc, 16'h0);
    en = 1'b1;
    CPU.load(64'h78563412_fe2318ff);
    check("page", mpc, 16'hf8);
    check("page bytes", mpb, 16'h3e00);
    check("card page", cpc, 16'h18);
    check("count", dcm, 16'h1);
    check("prot sel", pds, 16'h1);
    check("card en", cse, 16'h1);
    check("sub2", bsc, 16'h2);
    check("last", lb, 16'h5678);
    check("allowed", dal, 16'h9);
    check("pointer", ptr, 16'h0);
    check("done", done, 16'h1);
    check("main units", mpsu, 16'h1f);
    check("card units", cpsu, 16'h11);
    check("card bytes", cpb, 16'h2200);
    check("block code", ppbc, 16'h2);
    check("card on three", cd3, 16'h1);
    // block 2000h lies inside 1234h..5678h; only device 0 is selected
    pa = 24'h2000 << 7;
    dev = 2'h1;
    @(posedge ref_clk);
    #1;
    check("dev unsel", bp, 16'h0);
    dev = 2'h0;
    @(posedge ref_clk);
    #1;
    check("dev sel", bp, 16'h1);
    CPU.put(8'h44, 0);
    rst_b = 1'b0;
    @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    check("pointer rst", ptr, 16'h0);
    check("first rst", fb, 16'h0);
    for (int k = 0; k < 4; k++)
    begin
      desc = {8'h05, 8'h00, 8'h02, 8'h00, 6'h00, k[1:0], 8'h7e, 8'h08, 8'h08};
      CPU.load(desc);
      check("ppb", ppb, 16'h20 << k);
      check("8k page", mpb, 16'h2000);
      check("allowed all", dal, 16'hf);
      pa = 24'h3 << (5 + k);
      @(posedge ref_clk);
      #1;
      check("block", bn, 16'h3);
      check("inside", bp, 16'h1);
      pa = 24'h6 << (5 + k);
      @(posedge ref_clk);
      #1;
      check("outside", bp, 16'h0);
    end
    for (int i = 0; i < 8; i++)
    begin
      CPU.get(rb);
      check("readback", rb, desc[8*i +: 8]);
    end
    stop_test();
  end
endmodule // tb_top
